// file: rtl/ahp_pkg.sv
// Constants and types for the converter serial host port.
// Assumes a single system clock; all pins arrive from outside that domain.
//
// Behaviour
// - Sample from start fall to rise, select high
// - Mode 01 early start; sampling after deselect
// - Start rise with select high starts conversion
// - End-of-conversion low from sampling end to ready
// - End-of-conversion signalling only in mode 00
// - Interrupt falls on ready; select/sync fall clears
// - Sync low at select fall holds input off
// - Sync fall clears counter, enables input
// - Input off after 16 edges or select rise
// - Sync edges honoured regardless of select level
// - Power-down low sleeps; later select, sync or start fall wakes
// - Input MSB first; top nibble is command
// - Configuration write carries twelve data bits
// - Without sync, input latched on rising clock
// - With sync, input latched on falling clock
// - Output floats until first bit presented
// - Sync high: first bit at select fall, rising shifts
// - Sync low: first bit at sync low, falling shifts
// - Conversion reads: 12-bit result, four spare bits
// - Configuration read: register in final twelve bits
// - Output floats after sixteenth bit
// - Select fall clears counter, enables output; input if sync high
package ahp_pkg;

  // ------------------------------------------------------------
  // Frame and command layout
  // ------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int CMD_BITS = 4;
  localparam int DATA_BITS = 12;
  localparam logic [3:0] CNT_LAST = 4'hF;
  localparam logic [3:0] CNT_CMD_LAST = 4'h3;
  localparam logic [3:0] CMD_READ_CFG = 4'h9;
  localparam logic [3:0] CMD_WRITE_CFG = 4'hA;
  localparam logic [3:0] PAD_BITS = 4'h0;

  // Conversion mode field inside the configuration word
  localparam int CFG_MODE_LSB = 5;
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_REPEAT = 2'h1;
  localparam logic [11:0] CFG_RST = 12'h000;

  // ------------------------------------------------------------
  // Pin vector positions
  // ------------------------------------------------------------
  localparam int PIN_W = 6;
  localparam int PIN_SCLK = 0;
  localparam int PIN_SEL = 1;
  localparam int PIN_FS = 2;
  localparam int PIN_SI = 3;
  localparam int PIN_START = 4;
  localparam int PIN_PD = 5;
  localparam logic [5:0] PIN_RST = 6'h36;

  // ------------------------------------------------------------
  // Register port map
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_RESULT = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int CTRL_INT_SEL = 0;
  localparam logic CTRL_INT_SEL_RST = 1'b0;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CV_IDLE = 2'b00,
    CV_SAMPLE = 2'b01,
    CV_CONV = 2'b11
  } ahp_conv_state_type;

  typedef struct packed {
    logic done;
    logic [11:0] result;
  } ahp_core_in_type;

  typedef struct packed {
    logic valid;
    logic legal;
    logic [3:0] code;
  } ahp_cmd_type;

endpackage

// file: rtl/ahp_serial_port.sv
// Serial host port and conversion-control pin logic of a sampling converter.
// Assumes the host pins are asynchronous to clk_sys_i and much slower than it;
// the converter core reports completion with a one-cycle done pulse.
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps

module ahp_serial_port import ahp_pkg::*; #(
  parameter int NUM_CH = 8
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Host pins
  input wire logic sclk_i,
  input wire logic sel_n_i,
  input wire logic frame_sync_i,
  input wire logic serial_in_i,
  input wire logic sample_start_n_i,
  input wire logic power_down_n_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  output logic eoc_int_n_o,
  // Converter core side
  input ahp_core_in_type core_i,
  output logic sampling_o,
  output logic conv_start_o,
  output logic analog_on_o,
  output ahp_cmd_type cmd_o,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o
);

  // ------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ------------------------------------------------------------
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
  logic [PIN_W-1:0] pin_rise, pin_fall;

  assign pin_raw = {power_down_n_i, sample_start_n_i, serial_in_i, frame_sync_i, sel_n_i, sclk_i};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
      wire agree = s2_reg[gi] == s3_reg[gi];
      assign pin_rise[gi] = ce_i & agree & s3_reg[gi] & ~filt_reg[gi];
      assign pin_fall[gi] = ce_i & agree & ~s3_reg[gi] & filt_reg[gi];
      always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
          s1_reg[gi] <= PIN_RST[gi];
          s2_reg[gi] <= PIN_RST[gi];
          s3_reg[gi] <= PIN_RST[gi];
          filt_reg[gi] <= PIN_RST[gi];
        end else if (ce_i) begin
          s1_reg[gi] <= pin_raw[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (agree) begin
            filt_reg[gi] <= s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  wire sclk_rise = pin_rise[PIN_SCLK];
  wire sclk_fall = pin_fall[PIN_SCLK];
  wire sel_rise = pin_rise[PIN_SEL];
  wire sel_fall = pin_fall[PIN_SEL];
  wire fs_fall = pin_fall[PIN_FS];
  wire start_rise = pin_rise[PIN_START];
  wire start_fall = pin_fall[PIN_START];
  wire sel_high = filt_reg[PIN_SEL];
  wire fs_level = filt_reg[PIN_FS];
  wire si_level = filt_reg[PIN_SI];

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic si_en_reg, oe_reg, fs_mode_reg, cmd_seen_reg;
  logic [3:0] in_cnt_reg, out_cnt_reg;
  logic [FRAME_BITS-1:0] sh_in_reg, sh_out_reg;
  logic [DATA_BITS-1:0] cfg_reg, result_reg;
  ahp_cmd_type cmd_reg;
  ahp_conv_state_type cv_reg, cv_next;
  logic pend_reg, conv_start_reg, int_reg, pin_reg, awake_reg;
  logic int_sel_reg;
  logic [31:0] rdata_reg;

  // ------------------------------------------------------------
  // Frame decode
  // ------------------------------------------------------------
  wire frame_start = fs_fall | sel_fall;
  wire start_fs_mode = fs_fall | ~fs_level;
  wire start_si_en = fs_fall | fs_level;
  wire in_edge = si_en_reg & (fs_mode_reg ? sclk_fall : sclk_rise);
  wire out_edge = oe_reg & (fs_mode_reg ? sclk_fall : sclk_rise);
  wire [FRAME_BITS-1:0] in_word = {sh_in_reg[FRAME_BITS-2:0], si_level};
  wire [3:0] in_code = in_word[CMD_BITS-1:0];
  wire cmd_done = in_edge & (in_cnt_reg == CNT_CMD_LAST);
  wire word_done = in_edge & (in_cnt_reg == CNT_LAST);
  wire patch_cfg = cmd_done & (in_code == CMD_READ_CFG);
  wire code_legal = in_code[3] | (NUM_CH != 4) | ~in_code[0];
  wire [1:0] conv_mode = cfg_reg[CFG_MODE_LSB +: 2];
  wire [FRAME_BITS-1:0] load_word = {result_reg, PAD_BITS};

  // ------------------------------------------------------------
  // Serial frame engine
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      si_en_reg <= 1'b0;
      oe_reg <= 1'b0;
      fs_mode_reg <= 1'b0;
      cmd_seen_reg <= 1'b0;
      in_cnt_reg <= 4'h0;
      out_cnt_reg <= 4'h0;
      sh_in_reg <= 16'h0000;
      sh_out_reg <= 16'h0000;
      cfg_reg <= CFG_RST;
      cmd_reg <= '0;
    end else if (ce_i) begin
      cmd_reg.valid <= 1'b0;
      if (sel_rise) begin
        si_en_reg <= 1'b0;
        oe_reg <= 1'b0;
      end else if (frame_start) begin
        in_cnt_reg <= 4'h0;
        out_cnt_reg <= 4'h0;
        si_en_reg <= start_si_en;
        fs_mode_reg <= start_fs_mode;
        oe_reg <= 1'b1;
        sh_out_reg <= load_word;
        cmd_seen_reg <= 1'b0;
      end else begin
        if (in_edge) begin
          sh_in_reg <= in_word;
          in_cnt_reg <= in_cnt_reg + 4'h1;
          if (in_cnt_reg == CNT_LAST) begin
            si_en_reg <= 1'b0;
          end
        end
        if (cmd_done) begin
          cmd_seen_reg <= 1'b1;
          cmd_reg.valid <= 1'b1;
          cmd_reg.code <= in_code;
          cmd_reg.legal <= code_legal;
        end
        if (word_done && in_word[FRAME_BITS-1 -: CMD_BITS] == CMD_WRITE_CFG) begin
          cfg_reg <= in_word[DATA_BITS-1:0];
        end
        if (out_edge) begin
          out_cnt_reg <= out_cnt_reg + 4'h1;
          if (patch_cfg) begin
            sh_out_reg <= {cfg_reg, PAD_BITS};
          end else begin
            sh_out_reg <= {sh_out_reg[FRAME_BITS-2:0], 1'b0};
          end
          if (out_cnt_reg == CNT_LAST) begin
            oe_reg <= 1'b0;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Sampling and conversion control
  // ------------------------------------------------------------
  wire early_arm = start_fall & ~sel_high & cmd_seen_reg & (conv_mode == MODE_REPEAT);
  wire late_begin = sel_rise & pend_reg & ~filt_reg[PIN_START] & ~start_rise;
  // A start edge in the same cycle as the select rise counts as select high
  wire sel_up = sel_high | sel_rise;

  always_comb begin
    cv_next = cv_reg;
    unique case (cv_reg)
      CV_IDLE: begin
        if ((start_fall && sel_up) || late_begin) begin
          cv_next = CV_SAMPLE;
        end
      end
      CV_SAMPLE: begin
        if (start_rise && sel_up) begin
          cv_next = CV_CONV;
        end
      end
      CV_CONV: begin
        if (core_i.done) begin
          cv_next = CV_IDLE;
        end
      end
      default: cv_next = CV_IDLE;
    endcase
  end

  wire conv_begin = (cv_reg == CV_SAMPLE) & (cv_next == CV_CONV);
  wire conv_end = (cv_reg == CV_CONV) & core_i.done;
  wire eoc_active = (cv_next == CV_CONV) & (conv_mode == MODE_SINGLE);
  wire int_next = conv_end | (int_reg & ~frame_start);

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cv_reg <= CV_IDLE;
      pend_reg <= 1'b0;
      conv_start_reg <= 1'b0;
      result_reg <= 12'h000;
      int_reg <= 1'b0;
      pin_reg <= 1'b1;
    end else if (ce_i) begin
      cv_reg <= cv_next;
      conv_start_reg <= conv_begin;
      if (sel_rise || start_rise) begin
        pend_reg <= 1'b0;
      end else if (early_arm) begin
        pend_reg <= 1'b1;
      end
      if (conv_end) begin
        result_reg <= core_i.result;
      end
      int_reg <= int_next;
      pin_reg <= int_sel_reg ? ~int_next : ~eoc_active;
    end
  end

  // ------------------------------------------------------------
  // Power-down
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      awake_reg <= 1'b1;
    end else if (ce_i) begin
      if (!filt_reg[PIN_PD]) begin
        awake_reg <= 1'b0;
      end else if (sel_fall || fs_fall || start_fall) begin
        awake_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Register port
  // ------------------------------------------------------------
  wire hit_ctrl = addr_i == REG_CTRL;
  wire hit_cfg = addr_i == REG_CFG;
  wire hit_result = addr_i == REG_RESULT;
  wire hit_status = addr_i == REG_STATUS;
  wire [31:0] status_word = {24'h000000, cv_reg, awake_reg, pend_reg, int_reg,
                             fs_mode_reg, oe_reg, si_en_reg};
  wire [31:0] read_mux = hit_ctrl ? {31'h00000000, int_sel_reg} :
                         hit_cfg ? {20'h00000, cfg_reg} :
                         hit_result ? {20'h00000, result_reg} :
                         hit_status ? status_word : 32'h00000000;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      int_sel_reg <= CTRL_INT_SEL_RST;
      rdata_reg <= 32'h00000000;
    end else if (ce_i) begin
      if (wr_i && hit_ctrl) begin
        int_sel_reg <= wdata_i[CTRL_INT_SEL];
      end
      rdata_reg <= rd_i ? read_mux : 32'h00000000;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign serial_out_o = sh_out_reg[FRAME_BITS-1];
  assign serial_out_oe_o = oe_reg;
  assign eoc_int_n_o = pin_reg;
  assign sampling_o = (cv_reg == CV_SAMPLE);
  assign conv_start_o = conv_start_reg;
  assign analog_on_o = awake_reg;
  assign cmd_o = cmd_reg;
  assign rdata_o = rdata_reg;

endmodule

// file: verif/ahp_serial_port_props.sv
// Checker for the converter serial host port, bound to its top module.
// Assumes pins move well apart; attempts are dropped while the clock enable is low.
`timescale 1ns/1ps

module ahp_props import ahp_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input ahp_cmd_type cmd_o,
  input wire logic sel_n_i,
  input wire logic frame_sync_i,
  input wire logic sample_start_n_i,
  input wire logic power_down_n_i,
  input wire logic serial_out_oe_o,
  input wire logic eoc_int_n_o,
  input ahp_core_in_type core_i,
  input wire logic sampling_o,
  input wire logic conv_start_o,
  input wire logic analog_on_o,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i
);
  logic int_sel_reg;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      int_sel_reg <= CTRL_INT_SEL_RST;
    end else if (ce_i && wr_i && addr_i == REG_CTRL) begin
      int_sel_reg <= wdata_i[CTRL_INT_SEL];
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i || !ce_i);

  sequence s_sel_fall;
    $fell(sel_n_i) && frame_sync_i;
  endsequence
  sequence s_int_clear;
    int_sel_reg && $fell(sel_n_i) ##1 (!core_i.done) [*7];
  endsequence

  a_oe_on_select: assert property (s_sel_fall |-> ##[3:7] serial_out_oe_o)
    else $error("serial output not enabled after select fall");
  a_oe_off_deselect: assert property ($rose(sel_n_i) |-> ##[3:7] !serial_out_oe_o)
    else $error("serial output still driven after select rise");
  a_sample_begin: assert property ($fell(sample_start_n_i) && sel_n_i && power_down_n_i |-> ##[3:7] sampling_o)
    else $error("sampling did not begin");
  a_conv_on_rise: assert property ($rose(sample_start_n_i) && sel_n_i |-> ##[3:7] conv_start_o)
    else $error("conversion not started");
  a_conv_ends_sample: assert property (conv_start_o |-> $past(sampling_o) && !sampling_o)
    else $error("conversion start without sampling end");
  a_power_off: assert property ($fell(power_down_n_i) |-> ##[3:7] !analog_on_o)
    else $error("analog not powered down");
  a_int_on_done: assert property (int_sel_reg && core_i.done |-> ##1 !eoc_int_n_o)
    else $error("interrupt not raised after done");
  a_int_clear: assert property (s_int_clear |-> eoc_int_n_o)
    else $error("interrupt not cleared by select fall");
  a_cmd_pulse: assert property (cmd_o.valid |=> !cmd_o.valid)
    else $error("command valid longer than one cycle");
endmodule

bind ahp_serial_port ahp_props ahp_props_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce_i),
  .cmd_o(cmd_o), .sel_n_i(sel_n_i),
  .frame_sync_i(frame_sync_i), .sample_start_n_i(sample_start_n_i), .power_down_n_i(power_down_n_i),
  .serial_out_oe_o(serial_out_oe_o), .eoc_int_n_o(eoc_int_n_o), .core_i(core_i), .sampling_o(sampling_o),
  .conv_start_o(conv_start_o), .analog_on_o(analog_on_o), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i));

// file: verif/ahp_host_model.sv
// Host serial port model with a 320 ns serial clock.
// Assumes the device answers within a few system clocks of each pin edge.
`timescale 1ns/1ps

module ahp_host_model (
  output logic sclk_o,
  output logic sel_n_o,
  output logic frame_sync_o,
  output logic serial_in_o,
  input wire logic serial_out_i,
  input wire logic serial_out_oe_i
);
  logic last_bit = 1'b0;
  logic oe_seen;
  logic oe_after;

  initial begin
    #7;
    sclk_o = 1'b0;
    sel_n_o = 1'b1;
    frame_sync_o = 1'b1;
    serial_in_o = 1'b0;
  end

  always @(serial_out_i or serial_out_oe_i) if (serial_out_oe_i) last_bit = serial_out_i;

  // A released line shows the inverse of its last driven bit
  task automatic take(output logic b);
    b = serial_out_oe_i ? serial_out_i : ~last_bit;
    oe_seen &= serial_out_oe_i;
  endtask

  task automatic xfer(input logic fs_mode, input logic [15:0] din, output logic [15:0] dout);
    oe_seen = 1'b1;
    serial_in_o = din[15];
    sel_n_o = 1'b0;
    #640;
    if (fs_mode) begin
      frame_sync_o = 1'b0;
      #640;
    end
    for (int k = 15; k >= 0; k--) begin
      if (!fs_mode) serial_in_o = din[k];
      #160;
      if (!fs_mode) take(dout[k]);
      sclk_o = 1'b1;
      if (fs_mode) serial_in_o = din[k];
      #160;
      if (fs_mode) take(dout[k]);
      sclk_o = 1'b0;
    end
    #320;
    oe_after = serial_out_oe_i;
    sel_n_o = 1'b1;
    frame_sync_o = 1'b1;
    #640;
  endtask
endmodule

// file: verif/ahp_serial_port_tb.sv
// Self-checking bench for the converter serial host port.
// Assumes the host model file and the bound checker are compiled alongside.
`timescale 1ns/1ps

module ahp_serial_port_tb import ahp_pkg::*; ();
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic ce_i = 1'b1;
  logic sample_start_n_i = 1'b1;
  logic power_down_n_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [31:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  ahp_core_in_type core_i = '0;
  wire sclk_i, sel_n_i, frame_sync_i, serial_in_i;
  logic serial_out_o, serial_out_oe_o, eoc_int_n_o, sampling_o, conv_start_o, analog_on_o;
  ahp_cmd_type cmd_o;
  logic [31:0] rdata_o;
  logic [11:0] res_m = '0;
  logic [11:0] cfg_m = '0;
  logic [11:0] cd;
  logic int_sel_m = 1'b0;
  int seed = 8443;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #20 clk_sys_i = ~clk_sys_i;

  ahp_serial_port ahp_serial_port_i (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce_i), .sclk_i(sclk_i),
    .sel_n_i(sel_n_i), .frame_sync_i(frame_sync_i), .serial_in_i(serial_in_i),
    .sample_start_n_i(sample_start_n_i), .power_down_n_i(power_down_n_i), .serial_out_o(serial_out_o),
    .serial_out_oe_o(serial_out_oe_o), .eoc_int_n_o(eoc_int_n_o), .core_i(core_i), .sampling_o(sampling_o),
    .conv_start_o(conv_start_o), .analog_on_o(analog_on_o), .cmd_o(cmd_o), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
  ahp_host_model ahp_host_model_i (.sclk_o(sclk_i), .sel_n_o(sel_n_i), .frame_sync_o(frame_sync_i),
    .serial_in_o(serial_in_i), .serial_out_i(serial_out_o), .serial_out_oe_i(serial_out_oe_o));

  task automatic finish_test();
    $display("checks %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 8000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(negedge clk_sys_i);
    chk("read data", exp, rdata_o);
  endtask

  task automatic frm(input logic fs, input logic [15:0] din, input logic [15:0] exp, input logic [15:0] mask);
    logic [15:0] dout;
    ahp_host_model_i.xfer(fs, din, dout);
    chk("frame word", exp & mask, dout & mask);
    chk("output enable", 1, ahp_host_model_i.oe_seen);
    chk("output released", 0, ahp_host_model_i.oe_after);
  endtask

  task automatic conv(input logic [11:0] res, input logic eoc_exp, input logic early);
    if (!early) begin
      @(posedge clk_sys_i);
      sample_start_n_i <= 1'b0;
    end
    repeat (8) @(negedge clk_sys_i);
    chk("sampling", 1, sampling_o);
    @(posedge clk_sys_i);
    sample_start_n_i <= 1'b1;
    repeat (20) if (conv_start_o !== 1'b1) @(negedge clk_sys_i);
    chk("conversion start", 1, conv_start_o);
    repeat (2) @(negedge clk_sys_i);
    chk("eoc in conversion", eoc_exp, eoc_int_n_o);
    @(posedge clk_sys_i);
    core_i <= {1'b1, res};
    @(posedge clk_sys_i);
    core_i.done <= 1'b0;
    res_m = res;
    repeat (3) @(negedge clk_sys_i);
    chk("eoc after done", !int_sel_m, eoc_int_n_o);
  endtask

  initial begin
    repeat (16) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rd_chk(REG_CTRL, 0);
    rd_chk(REG_CFG, CFG_RST);
    wr(REG_RESULT, 32'h00000FFF);
    wr(8'h10, 32'h00000001);
    rd_chk(REG_RESULT, 0);
    rd_chk(8'h10, 0);
    for (int m = 0; m < 4; m++) begin
      cd = 12'($random(seed));
      cd[6:5] = m[1:0];
      // In the third frame the start pin falls early while mode 01 is still set
      fork
        frm(1'b0, {CMD_WRITE_CFG, cd}, {res_m, PAD_BITS}, 16'hFFFF);
        if (m == 2) begin
          repeat (60) @(posedge clk_sys_i);
          sample_start_n_i <= 1'b0;
          repeat (8) @(negedge clk_sys_i);
          chk("sampling held", 0, sampling_o);
        end
      join
      cfg_m = cd;
      chk("command", CMD_WRITE_CFG, cmd_o.code);
      chk("command legal", 1, cmd_o.legal);
      rd_chk(REG_CFG, cfg_m);
      conv(12'($random(seed)), m != 0, m == 2);
    end
    frm(1'b0, {CMD_WRITE_CFG, 12'hA9F}, {res_m, PAD_BITS}, 16'hFFFF);
    cfg_m = 12'hA9F;
    cd = 12'($random(seed));
    conv(cd, 1'b0, 1'b0);
    frm(1'b1, {CMD_READ_CFG, 12'h000}, {4'h0, cfg_m}, 16'h0FFF);
    frm(1'b1, 16'hE000, {res_m, PAD_BITS}, 16'hFFFF);
    wr(REG_CTRL, 32'h00000001);
    int_sel_m = 1'b1;
    rd_chk(REG_CTRL, 1);
    conv(12'($random(seed)), 1'b1, 1'b0);
    frm(1'b0, 16'hE000, {res_m, PAD_BITS}, 16'hFFFF);
    chk("interrupt cleared", 1, eoc_int_n_o);
    @(posedge clk_sys_i);
    power_down_n_i <= 1'b0;
    repeat (8) @(negedge clk_sys_i);
    chk("analog asleep", 0, analog_on_o);
    @(posedge clk_sys_i);
    power_down_n_i <= 1'b1;
    repeat (8) @(negedge clk_sys_i);
    chk("analog still asleep", 0, analog_on_o);
    conv(12'($random(seed)), 1'b1, 1'b0);
    chk("analog awake", 1, analog_on_o);
    // A power-down pulse while the clock enable is low must be lost
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    power_down_n_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    power_down_n_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    ce_i <= 1'b1;
    repeat (8) @(negedge clk_sys_i);
    chk("analog frozen", 1, analog_on_o);
    finish_test();
  end
endmodule
